// ---- design/wdcs_top.sv ----
// control and status logic of the eight bit watchdog counter
`timescale 1ns/10ps
`default_nettype none

module wdcs_top
    import wdcs_pkg::*;
(
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_n_i,
    input  wire logic [WDCS_ADDR_W-1:0] addr_i,
    input  wire logic [WDCS_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [WDCS_DATA_W-1:0] rdata_o,
    input  wire logic                   count_tick_i,
    output logic                        wdt_reset_o,
    output logic                        ovf_irq_o,
    output logic                        irq_o
);

    wdcs_state_t st;
    wdcs_state_t next_st;

    // counter interface
    logic       cnt_load;
    logic [7:0] cnt_load_data;
    logic       cnt_inc;
    logic [7:0] cnt_value;
    logic       cnt_wrap;

    // decoded accesses
    logic       wr_c1;
    logic       wr_s2;
    logic       wr_cnt;
    logic       wr_iclr;
    logic       wr_ien;
    logic       rd_s2;

    // register images as software sees them
    logic [7:0] img_c1;
    logic [7:0] img_s2;

    // event pulses for the interrupt status
    logic [WDCS_INT_W-1:0] int_events;

    // address decode of the plain register port
    always_comb begin
        wr_c1   = wr_i && (addr_i == WDCS_ADDR_CONTROL_ONE);
        wr_s2   = wr_i && (addr_i == WDCS_ADDR_STATUS_TWO);
        wr_cnt  = wr_i && (addr_i == WDCS_ADDR_COUNTER);
        wr_iclr = wr_i && (addr_i == WDCS_ADDR_INT_CLEAR);
        wr_ien  = wr_i && (addr_i == WDCS_ADDR_INT_ENABLE);
        rd_s2   = rd_i && (addr_i == WDCS_ADDR_STATUS_TWO);
    end

    // protect bits have no storage and always read back as 1
    always_comb begin
        img_c1 = 8'hff;
        img_c1[WDCS_C1_CNT_WE]   = st.cnt_we;
        img_c1[WDCS_C1_REG_WE]   = st.reg_we;
        img_c1[WDCS_C1_ON]       = st.wd_on;
        img_c1[WDCS_C1_RST_FLAG] = st.rst_flag;
        img_s2 = 8'hff;
        img_s2[WDCS_S2_OVF]      = st.ovf;
        img_s2[WDCS_S2_MODE]     = st.mode_interval;
        img_s2[WDCS_S2_IEOVF]    = st.ieovf;
        img_s2[2:0]              = WDCS_S2_RSVD_VALUE;
    end

    // counter control: the internal reset forces the count back to zero,
    // a software write needs the counter write enable
    always_comb begin
        cnt_load      = st.rst_pulse || (wr_cnt && st.cnt_we);
        cnt_load_data = st.rst_pulse ? WDCS_COUNTER_RESET : wdata_i;
        // the tick comes from an external prescaler; no tick, no count
        cnt_inc       = st.wd_on && count_tick_i && !st.rst_pulse;
    end

    wdcs_counter u_counter (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .load_i      (cnt_load),
        .load_data_i (cnt_load_data),
        .inc_i       (cnt_inc),
        .count_o     (cnt_value),
        .wrap_o      (cnt_wrap)
    );

    // events that feed the sticky interrupt status
    always_comb begin
        int_events                    = '0;
        int_events[WDCS_INT_OVF]      = cnt_wrap;
        int_events[WDCS_INT_WDT_RESET] = st.rst_pulse;
    end

    // next state of every control and status bit
    always_comb begin
        next_st = st;

        // one cycle pulse unless re-armed below
        next_st.rst_pulse = 1'b0;

        // control one writes: each protected bit only moves when its
        // protect bit in the same data is 0
        if (wr_c1) begin
            if (!wdata_i[WDCS_C1_CNT_WE_PROT]) begin
                next_st.cnt_we = wdata_i[WDCS_C1_CNT_WE];
            end
            if (!wdata_i[WDCS_C1_REG_WE_PROT]) begin
                next_st.reg_we = wdata_i[WDCS_C1_REG_WE];
            end
            // the old enable value gates this write, not the one in the data
            if (st.reg_we) begin
                if (!wdata_i[WDCS_C1_ON_PROT]) begin
                    next_st.wd_on = wdata_i[WDCS_C1_ON];
                end
                if (!wdata_i[WDCS_C1_RST_PROT] && !wdata_i[WDCS_C1_RST_FLAG]) begin
                    next_st.rst_flag = 1'b0;
                end
            end
        end

        // status two writes
        if (wr_s2) begin
            if (!wdata_i[WDCS_S2_MODE_PROT]) begin
                next_st.mode_interval = wdata_i[WDCS_S2_MODE];
            end
            if (!wdata_i[WDCS_S2_IEOVF_PROT]) begin
                next_st.ieovf = wdata_i[WDCS_S2_IEOVF];
            end
            // a zero clears only after a read saw the flag set
            if (st.ovf_armed && !wdata_i[WDCS_S2_OVF]) begin
                next_st.ovf = 1'b0;
            end
            // any write ends the read-then-write sequence
            next_st.ovf_armed = 1'b0;
        end

        // a read that sees the flag set arms the clear
        if (rd_s2 && st.ovf) begin
            next_st.ovf_armed = 1'b1;
        end

        // internal reset: return the control one and status two bits to their reset state, but
        // set the reset flag so software can tell why it restarted
        if (st.rst_pulse) begin
            next_st.cnt_we        = 1'b0;
            next_st.reg_we        = 1'b0;
            next_st.wd_on         = 1'b0;
            next_st.mode_interval = 1'b0;
            next_st.ieovf         = 1'b0;
            next_st.ovf           = 1'b0;
            next_st.ovf_armed     = 1'b0;
            next_st.rst_flag      = 1'b1;
        end

        // an overflow in this cycle wins over a clear in the same cycle
        if (cnt_wrap) begin
            next_st.ovf = 1'b1;
            if (!st.mode_interval) begin
                next_st.rst_pulse = 1'b1;
            end
        end

        // interrupt enable and sticky status; set wins over clear
        if (wr_ien) begin
            next_st.int_enable = wdata_i[WDCS_INT_W-1:0];
        end
        if (wr_iclr) begin
            next_st.int_status = st.int_status & ~wdata_i[WDCS_INT_W-1:0];
        end
        next_st.int_status = next_st.int_status | int_events;

        // level outputs follow the registered state
        next_st.irq     = |(next_st.int_status & next_st.int_enable);
        next_st.ovf_irq = next_st.ovf && next_st.ieovf && next_st.mode_interval;

        // read data stand in the cycle after the strobe and only there
        next_st.rdata = WDCS_RDATA_RESET;
        if (rd_i) begin
            case (addr_i)
                WDCS_ADDR_CONTROL_ONE: begin
                    next_st.rdata = img_c1;
                end
                WDCS_ADDR_STATUS_TWO: begin
                    next_st.rdata = img_s2;
                end
                WDCS_ADDR_COUNTER: begin
                    next_st.rdata = cnt_value;
                end
                WDCS_ADDR_INT_STATUS: begin
                    next_st.rdata = {6'h00, st.int_status};
                end
                WDCS_ADDR_INT_ENABLE: begin
                    next_st.rdata = {6'h00, st.int_enable};
                end
                default: begin
                    // unmapped and write-only addresses read as zero
                    next_st.rdata = WDCS_RDATA_RESET;
                end
            endcase
        end
    end

    // all state in one register; device and pin reset share reset_n_i
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st.cnt_we        <= 1'b0;
            st.reg_we        <= 1'b0;
            st.wd_on         <= 1'b0;
            st.rst_flag      <= 1'b0;
            st.mode_interval <= 1'b0;
            st.ieovf         <= 1'b0;
            st.ovf           <= 1'b0;
            st.ovf_armed     <= 1'b0;
            st.rst_pulse     <= 1'b0;
            st.int_status    <= WDCS_INT_RESET;
            st.int_enable    <= WDCS_INT_RESET;
            st.irq           <= 1'b0;
            st.ovf_irq       <= 1'b0;
            st.rdata         <= WDCS_RDATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign rdata_o     = st.rdata;
    assign wdt_reset_o = st.rst_pulse;
    assign ovf_irq_o   = st.ovf_irq;
    assign irq_o       = st.irq;

endmodule // wdcs_top

`default_nettype wire

// ---- design/wdcs_pkg.sv ----
// package with register map, field positions and state types of the watchdog control block
package wdcs_pkg;

    // bus widths
    localparam int unsigned WDCS_ADDR_W = 16;
    localparam int unsigned WDCS_DATA_W = 8;

    // register byte addresses
    localparam logic [15:0] WDCS_ADDR_CONTROL_ONE = 16'hffb1;
    localparam logic [15:0] WDCS_ADDR_STATUS_TWO  = 16'hffb2;
    localparam logic [15:0] WDCS_ADDR_COUNTER     = 16'hffb3;
    localparam logic [15:0] WDCS_ADDR_INT_STATUS  = 16'hffb4;
    localparam logic [15:0] WDCS_ADDR_INT_CLEAR   = 16'hffb5;
    localparam logic [15:0] WDCS_ADDR_INT_ENABLE  = 16'hffb6;

    // watchdog_control_one field positions
    localparam int unsigned WDCS_C1_CNT_WE_PROT = 7;
    localparam int unsigned WDCS_C1_CNT_WE      = 6;
    localparam int unsigned WDCS_C1_REG_WE_PROT = 5;
    localparam int unsigned WDCS_C1_REG_WE      = 4;
    localparam int unsigned WDCS_C1_ON_PROT     = 3;
    localparam int unsigned WDCS_C1_ON          = 2;
    localparam int unsigned WDCS_C1_RST_PROT    = 1;
    localparam int unsigned WDCS_C1_RST_FLAG    = 0;

    // watchdog_status_two field positions
    localparam int unsigned WDCS_S2_OVF         = 7;
    localparam int unsigned WDCS_S2_MODE_PROT   = 6;
    localparam int unsigned WDCS_S2_MODE        = 5;
    localparam int unsigned WDCS_S2_IEOVF_PROT  = 4;
    localparam int unsigned WDCS_S2_IEOVF       = 3;
    localparam logic [2:0]  WDCS_S2_RSVD_VALUE  = 3'h7;

    // interrupt status layout
    localparam int unsigned WDCS_INT_OVF        = 0;
    localparam int unsigned WDCS_INT_WDT_RESET  = 1;
    localparam int unsigned WDCS_INT_W          = 2;

    // reset values and the counter top value
    localparam logic [7:0]  WDCS_COUNTER_RESET  = 8'h00;
    localparam logic [7:0]  WDCS_COUNTER_MAX    = 8'hff;
    localparam logic [1:0]  WDCS_INT_RESET      = 2'h0;
    localparam logic [7:0]  WDCS_RDATA_RESET    = 8'h00;

    // state of the counter module
    typedef struct packed {
        logic [7:0] count;
    } wdcs_cnt_state_t;

    // state of the control and status block
    typedef struct packed {
        logic                   cnt_we;
        logic                   reg_we;
        logic                   wd_on;
        logic                   rst_flag;
        logic                   mode_interval;
        logic                   ieovf;
        logic                   ovf;
        logic                   ovf_armed;
        logic                   rst_pulse;
        logic [WDCS_INT_W-1:0]  int_status;
        logic [WDCS_INT_W-1:0]  int_enable;
        logic                   irq;
        logic                   ovf_irq;
        logic [7:0]             rdata;
    } wdcs_state_t;

endpackage

// ---- design/wdcs_counter.sv ----
// eight bit up-counter with load and wrap detection
`timescale 1ns/10ps
`default_nettype none

module wdcs_counter
    import wdcs_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_data_i,
    input  wire logic       inc_i,
    output logic      [7:0] count_o,
    output logic            wrap_o
);

    wdcs_cnt_state_t st;
    wdcs_cnt_state_t next_st;

    // load beats increment so a software write is never lost to a tick
    always_comb begin
        next_st = st;
        if (load_i) begin
            next_st.count = load_data_i;
        end else if (inc_i) begin
            next_st.count = st.count + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st.count <= WDCS_COUNTER_RESET;
        end else begin
            st <= next_st;
        end
    end

    // wrap from the top value to zero on this cycle's tick
    assign count_o = st.count;
    assign wrap_o  = inc_i && !load_i && (st.count == WDCS_COUNTER_MAX);

endmodule // wdcs_counter

`default_nettype wire

// ---- test/wdcs_top_properties.sv ----
// port-level assertions and covers of the watchdog control block
`timescale 1ns/10ps
`default_nettype none

module wdcs_top_properties
    import wdcs_pkg::*;
(
    input wire logic                   ref_clk_i,
    input wire logic                   reset_n_i,
    input wire logic [WDCS_ADDR_W-1:0] addr_i,
    input wire logic [WDCS_DATA_W-1:0] wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [WDCS_DATA_W-1:0] rdata_o,
    input wire logic                   count_tick_i,
    input wire logic                   wdt_reset_o,
    input wire logic                   ovf_irq_o,
    input wire logic                   irq_o
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // read data only stands in the cycle after a read
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read cycle");
    a_ctrl_ones: assert property (rd_i && addr_i == WDCS_ADDR_CONTROL_ONE
        |=> (rdata_o & 8'haa) == 8'haa) else $error("control protect bits not read as one");
    a_stat_ones: assert property (rd_i && addr_i == WDCS_ADDR_STATUS_TWO
        |=> (rdata_o & 8'h57) == 8'h57) else $error("status fixed bits not read as one");
    a_pulse_once: assert property (wdt_reset_o |=> !wdt_reset_o)
        else $error("internal reset longer than one cycle");
    // after the internal reset the flag stands and the control bits are cleared;
    // writes are excluded in between, since software may legally set them again
    a_flag_after_rst: assert property (wdt_reset_o ##1 !wr_i ##1 !wr_i
        ##1 (rd_i && addr_i == WDCS_ADDR_CONTROL_ONE) |=> (rdata_o & 8'h55) == 8'h01)
        else $error("reset flag not set after internal reset");
    a_ovf_auto: assert property (wdt_reset_o ##[1:4]
        (rd_i && addr_i == WDCS_ADDR_STATUS_TWO) |=> !rdata_o[7])
        else $error("overflow flag not cleared by internal reset");
    // two counter reads with no tick in between must agree
    a_count_hold: assert property ((rd_i && addr_i == WDCS_ADDR_COUNTER && !count_tick_i
        && !wdt_reset_o) ##1 (!count_tick_i && !wr_i && !wdt_reset_o)
        ##1 (rd_i && addr_i == WDCS_ADDR_COUNTER) |=> rdata_o == $past(rdata_o, 2))
        else $error("counter moved without a tick");
    a_irq_excl: assert property (ovf_irq_o |-> !wdt_reset_o)
        else $error("interval interrupt beside internal reset");

    c_wdt_reset: cover property (wdt_reset_o);
    c_ovf_irq: cover property (ovf_irq_o);
    c_irq: cover property (irq_o);
endmodule // wdcs_top_properties

bind wdcs_top wdcs_top_properties chk_u (.ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .count_tick_i, .wdt_reset_o, .ovf_irq_o, .irq_o);

`default_nettype wire

// ---- test/wdcs_top_test.sv ----
// self-checking bench of the watchdog control block
`timescale 1ns/10ps
`default_nettype none

module wdcs_top_test
    import wdcs_pkg::*;
;
    localparam logic [15:0] A1 = WDCS_ADDR_CONTROL_ONE;
    localparam logic [15:0] A2 = WDCS_ADDR_STATUS_TWO;
    localparam logic [15:0] AC = WDCS_ADDR_COUNTER;
    logic        ref_clk_i    = 1'b0;
    logic        reset_n_i    = 1'b0;
    logic [15:0] addr_i       = 16'h0000;
    logic [7:0]  wdata_i      = 8'h00;
    logic        wr_i         = 1'b0;
    logic        rd_i         = 1'b0;
    logic        count_tick_i = 1'b0;
    logic [7:0]  rdata_o;
    logic        wdt_reset_o;
    logic        ovf_irq_o;
    logic        irq_o;
    int          n_errors        = 0;
    int          samples_checked = 0;
    logic [31:0] seed            = 32'hb42f;
    logic [7:0]  n_pulse         = 8'h00;
    logic [3:0]  c1;
    logic [7:0]  v;
    logic [7:0]  k;

    always #50 ref_clk_i = ~ref_clk_i;

    wdcs_top dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .count_tick_i(count_tick_i), .wdt_reset_o(wdt_reset_o), .ovf_irq_o(ovf_irq_o),
        .irq_o(irq_o));

    // the reset pulse is caught here since tasks may be busy on the bus
    always @(posedge ref_clk_i) if (wdt_reset_o === 1'b1) n_pulse <= n_pulse + 8'h01;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // control one model {cnt_we, reg_we, on, flag}; each bit obeys its own protect bit
    function automatic logic [3:0] c1_next(input logic [3:0] o, input logic [7:0] w);
        logic [3:0] n;
        n = o;
        if (!w[7]) n[3] = w[6];
        if (!w[5]) n[2] = w[4];
        if (!w[3] && o[2]) n[1] = w[2];
        if (!w[1] && !w[0] && o[2]) n[0] = 1'b0;
        return n;
    endfunction

    function automatic logic [7:0] c1_img(input logic [3:0] s);
        return {1'b1, s[3], 1'b1, s[2], 1'b1, s[1], 1'b1, s[0]};
    endfunction

    task automatic end_sim();
        $display("n_errors=%0d samples_checked=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] w);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= w;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    // read data is taken mid-cycle, after the answering edge has settled
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(rdata_o, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            count_tick_i <= 1'b1;
        end
        @(posedge ref_clk_i);
        count_tick_i <= 1'b0;
    endtask

    // run limit far above the few hundred cycles the sequence needs
    initial begin
        #500000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rdc(A1, 8'haa);
        rdc(A2, 8'h57);
        rdc(AC, 8'h00);
        rdc(WDCS_ADDR_INT_CLEAR, 8'h00);
        rdc(16'hffb0, 8'h00);
        wr(AC, 8'h3c);
        rdc(AC, 8'h00);
        wr(A1, 8'h34);
        rdc(A1, 8'haa);
        // random control writes checked against the bit model
        c1 = 4'h0;
        repeat (40) begin
            seed = xs(seed);
            wr(A1, seed[7:0]);
            c1 = c1_next(c1, seed[7:0]);
            rdc(A1, c1_img(c1));
        end
        wr(A1, 8'h5f);
        wr(A1, 8'hf3);
        rdc(A1, 8'hfa);
        seed = xs(seed);
        v = {1'b0, seed[6:0]};
        k = {5'h00, seed[10:8]} + 8'h01;
        wr(AC, v);
        tick(5);
        rdc(AC, v);
        rdc(AC, v);
        wr(A1, 8'hf7);
        tick(k);
        rdc(AC, v + k);
        // watchdog overflow with its interrupt masked
        wr(WDCS_ADDR_INT_ENABLE, 8'h00);
        wr(AC, 8'hfe);
        tick(2);
        rdc(A2, 8'h57);
        rdc(A1, 8'hab);
        chk(n_pulse, 8'h01);
        rdc(WDCS_ADDR_INT_STATUS, 8'h03);
        chk({7'h00, irq_o}, 8'h00);
        wr(WDCS_ADDR_INT_ENABLE, 8'h03);
        @(negedge ref_clk_i);
        chk({7'h00, irq_o}, 8'h01);
        wr(WDCS_ADDR_INT_CLEAR, 8'h03);
        @(negedge ref_clk_i);
        chk({7'h00, irq_o}, 8'h00);
        rdc(WDCS_ADDR_INT_STATUS, 8'h00);
        // flag clear needs the register write enable first
        wr(A1, 8'hfc);
        rdc(A1, 8'hab);
        wr(A1, 8'hdf);
        wr(A1, 8'hfc);
        rdc(A1, 8'hba);
        // interval mode: flag stays until a read that saw it is followed by a write of 0
        wr(A2, 8'h28);
        rdc(A2, 8'h7f);
        wr(A1, 8'h5f);
        wr(AC, 8'hfe);
        wr(A1, 8'hf7);
        tick(2);
        @(negedge ref_clk_i);
        chk({7'h00, ovf_irq_o}, 8'h01);
        wr(A2, 8'h28);
        rdc(A2, 8'hff);
        wr(A2, 8'h28);
        rdc(A2, 8'h7f);
        chk({7'h00, ovf_irq_o}, 8'h00);
        chk(n_pulse, 8'h01);
        end_sim();
    end
endmodule // wdcs_top_test

`default_nettype wire
